// ===== hdl/srp_map.vh
// register map, field positions and timing counts of the serial port host
// assumes a 20 MHz mclk and an apb master on the same clock
`ifndef SRP_MAP_VH
`define SRP_MAP_VH

// apb word offsets
`define SRP_OFF_CTRL      8'h00
`define SRP_OFF_STATUS    8'h04
`define SRP_OFF_ADDR      8'h08
`define SRP_OFF_WDATA     8'h0c
`define SRP_OFF_RDATA     8'h10

// control word fields
`define SRP_CTRL_GO       0
`define SRP_CTRL_SPI      1
`define SRP_CTRL_READ     2
`define SRP_CTRL_3W       3
`define SRP_CTRL_LSB      4
`define SRP_CTRL_CNT_LO   5
`define SRP_CTRL_CNT_HI   6

// status word fields
`define SRP_STAT_BUSY     0
`define SRP_STAT_DONE     1
`define SRP_STAT_NACK     2

// reset values
`define SRP_RST_WORD      32'h0000_0000
`define SRP_RST_ADDR      7'h00

// fixed upper six bits of the i2c slave address
`define SRP_I2C_ADDR_HI   6'h2e

// link timing
`define SRP_MCLK_HZ       20000000
`define SRP_I2C_MAX_HZ    400000
`define SRP_QTR_CYC       ((`SRP_MCLK_HZ + 4 * `SRP_I2C_MAX_HZ - 1) / (4 * `SRP_I2C_MAX_HZ))

`endif

// ===== hdl/srp_sync.v
// two-flop synchroniser for the pin inputs
// assumes pins idle high while released
`timescale 1ns/1ns
module srp_sync #(
  parameter W = 3
) (
  // clock and reset
  input  wire         mclk,
  input  wire         rst,
  // pins and synchronised copy
  input  wire [W-1:0] pin_i,
  output reg  [W-1:0] sync_q
);

  reg [W-1:0] meta_q;

  always @(posedge mclk) begin
    if (rst) begin
      meta_q <= {W{1'b1}};
      sync_q <= {W{1'b1}};
    end else begin
      meta_q <= pin_i;
      sync_q <= meta_q;
    end
  end

endmodule // srp_sync

// ===== hdl/srp_tick.v
// quarter-bit tick for the link clock divider
// assumes clear is held while the engine is idle
`timescale 1ns/1ns
`include "srp_map.vh"
module srp_tick (
  // clock and reset
  input  wire mclk,
  input  wire rst,
  // control and tick
  input  wire clr,
  output reg  tick_q
);

  localparam integer QTR_LAST = `SRP_QTR_CYC - 1;

  reg [3:0] cnt_q;

  always @(posedge mclk) begin
    if (rst || clr) begin
      cnt_q  <= 4'h0;
      tick_q <= 1'b0;
    end else if (cnt_q == QTR_LAST[3:0]) begin
      cnt_q  <= 4'h0;
      tick_q <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 4'h1;
      tick_q <= 1'b0;
    end
  end

endmodule // srp_tick

// ===== hdl/srp_host.v
// host controller for the serial register port: i2c or 3/4-wire spi master
// assumes apb on mclk, pins synchronised here, pull-ups on scl and sda
//
// What this block does
// - chip-select high gives i2c, low gives spi
// - receiver pulls data low through acknowledge high
// - pointer byte follows address, top bit ignored
// - read: address write, pointer, repeated start, address read
// - master acks to continue, nacks then stops
// - eight bits per byte, msb first, one to four bytes
// - receiver may stretch clock low to stall
// - unacknowledged byte lets master abort transfer
// - start and stop are data edges, clock high
// - i2c clock no faster than fast mode
// - chip-select low per frame, clock parked high
// - spi data change on fall, sampled on rise
// - sixteen clocks plus eight per extra byte
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`include "srp_map.vh"
module srp_host (
  // clock and reset
  input  wire        mclk,
  input  wire        rst,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // chip select
  output reg         cs_o,
  // scl / spi_serial_clock
  input  wire        scl_i,
  output reg         scl_o,
  output reg         scl_oe,
  // sda / spi_data_in
  input  wire        sda_i,
  output reg         sda_o,
  output reg         sda_oe,
  // spi_data_out
  input  wire        sdo_i
);

  localparam [2:0] SM_IDLE   = 3'd0;
  localparam [2:0] SM_ISTART = 3'd1;
  localparam [2:0] SM_IBIT   = 3'd2;
  localparam [2:0] SM_ISTOP  = 3'd3;
  localparam [2:0] SM_SBIT   = 3'd4;
  localparam [2:0] SM_SEND   = 3'd5;
  localparam [2:0] SM_DONE   = 3'd6;

  localparam [2:0] PH_AW  = 3'd0;
  localparam [2:0] PH_SUB = 3'd1;
  localparam [2:0] PH_WR  = 3'd2;
  localparam [2:0] PH_AR  = 3'd3;
  localparam [2:0] PH_RD  = 3'd4;

  function [7:0] byte_sel;
    input [31:0] w;
    input [1:0]  i;
    begin
      byte_sel = w[{i, 3'b000} +: 8];
    end
  endfunction

  function [31:0] byte_put;
    input [31:0] w;
    input [1:0]  i;
    input [7:0]  b;
    begin
      byte_put = (w & ~(32'h0000_00ff << {i, 3'b000}))
               | ({24'h00_0000, b} << {i, 3'b000});
    end
  endfunction

  reg         spi_q;
  reg         rd_q;
  reg         tw_q;
  reg         lsb_q;
  reg  [1:0]  cnt_q;
  reg  [6:0]  addr_q;
  reg  [31:0] wdata_q;
  reg  [31:0] rdata_q;
  reg         busy_q;
  reg         done_q;
  reg         nack_q;
  reg  [2:0]  fsm_q;
  reg  [1:0]  qtr_q;
  reg  [3:0]  bit_q;
  reg  [5:0]  sb_q;
  reg  [2:0]  ph_q;
  reg  [1:0]  byte_q;
  reg  [7:0]  sh_q;
  reg  [31:0] rdmux_d;
  reg         err_d;

  wire [2:0]  pin_s;
  wire        tick;
  wire        scl_s = pin_s[0];
  wire        sda_s = pin_s[1];
  wire        sdo_s = pin_s[2];
  wire        apb_setup = psel & ~penable;
  wire        apb_wr = psel & penable & pready & pwrite;
  wire        go = apb_wr & (paddr == `SRP_OFF_CTRL)
                 & pwdata[`SRP_CTRL_GO] & ~busy_q;
  wire        stat_clr = apb_wr & (paddr == `SRP_OFF_STATUS);
  wire        tx_ph = (ph_q != PH_RD);
  wire        nack_set = (fsm_q == SM_IBIT) & tick & (qtr_q == 2'd2)
                       & scl_s & (bit_q == 4'd8) & tx_ph & sda_s;
  wire        last_byte = (byte_q == cnt_q);
  wire [5:0]  sb_last = 6'd15 + {1'b0, cnt_q, 3'b000};
  wire [1:0]  blk = sb_q[4:3];
  wire        spi_miso = tw_q ? sda_s : sdo_s;

  srp_sync #(
    .W (3)
  ) u_sync (
    .mclk   (mclk),
    .rst    (rst),
    .pin_i  ({sdo_i, sda_i, scl_i}),
    .sync_q (pin_s)
  );

  srp_tick u_tick (
    .mclk   (mclk),
    .rst    (rst),
    .clr    (fsm_q == SM_IDLE),
    .tick_q (tick)
  );

  always @* begin
    rdmux_d = 32'h0000_0000;
    err_d   = 1'b0;
    case (paddr)
      `SRP_OFF_CTRL: begin
        rdmux_d = {25'h000_0000, cnt_q, lsb_q, tw_q, rd_q, spi_q, 1'b0};
      end
      `SRP_OFF_STATUS: begin
        rdmux_d = {29'h0000_0000, nack_q, done_q, busy_q};
      end
      `SRP_OFF_ADDR: begin
        rdmux_d = {25'h000_0000, addr_q};
      end
      `SRP_OFF_WDATA: begin
        rdmux_d = wdata_q;
      end
      `SRP_OFF_RDATA: begin
        rdmux_d = rdata_q;
      end
      default: begin
        err_d = 1'b1;
      end
    endcase
  end

  // apb slave: zero wait states, answer in the access cycle
  always @(posedge mclk) begin
    if (rst) begin
      prdata  <= `SRP_RST_WORD;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= apb_setup;
      pslverr <= apb_setup & err_d;
      if (apb_setup && !pwrite)
        prdata <= rdmux_d;
    end
  end

  // configuration, held steady while a transfer runs
  always @(posedge mclk) begin
    if (rst) begin
      spi_q   <= 1'b0;
      rd_q    <= 1'b0;
      tw_q    <= 1'b0;
      lsb_q   <= 1'b0;
      cnt_q   <= 2'b00;
      addr_q  <= `SRP_RST_ADDR;
      wdata_q <= `SRP_RST_WORD;
    end else if (apb_wr && !busy_q) begin
      if (paddr == `SRP_OFF_CTRL) begin
        spi_q <= pwdata[`SRP_CTRL_SPI];
        rd_q  <= pwdata[`SRP_CTRL_READ];
        tw_q  <= pwdata[`SRP_CTRL_3W];
        lsb_q <= pwdata[`SRP_CTRL_LSB];
        cnt_q <= pwdata[`SRP_CTRL_CNT_HI:`SRP_CTRL_CNT_LO];
      end
      if (paddr == `SRP_OFF_ADDR)
        addr_q <= pwdata[6:0];
      if (paddr == `SRP_OFF_WDATA)
        wdata_q <= pwdata;
    end
  end

  // sticky flags: a hardware set wins over a software clear
  always @(posedge mclk) begin
    if (rst) begin
      done_q <= 1'b0;
      nack_q <= 1'b0;
    end else begin
      done_q <= (fsm_q == SM_DONE)
              | (done_q & ~(stat_clr & pwdata[`SRP_STAT_DONE]));
      nack_q <= nack_set
              | (nack_q & ~(stat_clr & pwdata[`SRP_STAT_NACK]));
    end
  end

  // link engine, one quarter bit per tick
  always @(posedge mclk) begin
    if (rst) begin
      fsm_q   <= SM_IDLE;
      busy_q  <= 1'b0;
      qtr_q   <= 2'b00;
      bit_q   <= 4'h0;
      sb_q    <= 6'h00;
      ph_q    <= PH_AW;
      byte_q  <= 2'b00;
      sh_q    <= 8'h00;
      rdata_q <= `SRP_RST_WORD;
      cs_o    <= 1'b1;
      scl_o   <= 1'b0;
      scl_oe  <= 1'b0;
      sda_o   <= 1'b0;
      sda_oe  <= 1'b0;
    end else begin
      case (fsm_q)
        SM_IDLE: begin
          cs_o   <= 1'b1;
          scl_o  <= spi_q;
          scl_oe <= spi_q;
          sda_o  <= spi_q;
          sda_oe <= spi_q;
          qtr_q  <= 2'b00;
          byte_q <= 2'b00;
          if (go) begin
            busy_q <= 1'b1;
            if (pwdata[`SRP_CTRL_SPI]) begin
              cs_o  <= 1'b0;
              scl_o <= 1'b1;
              scl_oe <= 1'b1;
              // data idles high so the pins never show a start
              sda_o  <= 1'b1;
              sda_oe <= 1'b1;
              sb_q  <= 6'h00;
              sh_q  <= {pwdata[`SRP_CTRL_READ], addr_q};
              fsm_q <= SM_SBIT;
            end else begin
              ph_q  <= PH_AW;
              fsm_q <= SM_ISTART;
            end
          end
        end
        SM_ISTART: begin
          if (tick) begin
            if (qtr_q == 2'd0) begin
              sda_oe <= 1'b0;
              qtr_q  <= 2'd1;
            end else if (qtr_q == 2'd1) begin
              scl_oe <= 1'b0;
              qtr_q  <= 2'd2;
            end else if (qtr_q == 2'd2) begin
              if (scl_s) begin
                sda_oe <= 1'b1;
                qtr_q  <= 2'd3;
              end
            end else begin
              scl_oe <= 1'b1;
              qtr_q  <= 2'd0;
              bit_q  <= 4'h0;
              sh_q   <= {`SRP_I2C_ADDR_HI, lsb_q, ph_q == PH_AR};
              fsm_q  <= SM_IBIT;
            end
          end
        end
        SM_IBIT: begin
          if (tick) begin
            if (qtr_q == 2'd0) begin
              if (bit_q != 4'd8)
                sda_oe <= tx_ph & ~sh_q[7];
              else
                sda_oe <= ~tx_ph & ~last_byte;
              qtr_q <= 2'd1;
            end else if (qtr_q == 2'd1) begin
              scl_oe <= 1'b0;
              qtr_q  <= 2'd2;
            end else if (qtr_q == 2'd2) begin
              if (scl_s) begin
                if (bit_q != 4'd8)
                  sh_q <= {sh_q[6:0], sda_s};
                else if (tx_ph)
                  sh_q[0] <= sda_s;
                qtr_q <= 2'd3;
              end
            end else begin
              scl_oe <= 1'b1;
              qtr_q  <= 2'd0;
              bit_q  <= bit_q + 4'h1;
              if (bit_q == 4'd8) begin
                bit_q <= 4'h0;
                // abort on this byte's own nack, not on a stale flag
                if (tx_ph && sh_q[0]) begin
                  fsm_q <= SM_ISTOP;
                end else begin
                  case (ph_q)
                    PH_AW: begin
                      ph_q <= PH_SUB;
                      sh_q <= {1'b0, addr_q};
                    end
                    PH_SUB: begin
                      if (rd_q) begin
                        ph_q <= PH_AR;
                        fsm_q <= SM_ISTART;
                      end else begin
                        ph_q <= PH_WR;
                        sh_q <= byte_sel(wdata_q, 2'b00);
                      end
                    end
                    PH_WR: begin
                      if (last_byte) begin
                        fsm_q <= SM_ISTOP;
                      end else begin
                        byte_q <= byte_q + 2'b01;
                        sh_q <= byte_sel(wdata_q, byte_q + 2'b01);
                      end
                    end
                    PH_AR: begin
                      ph_q <= PH_RD;
                    end
                    default: begin
                      rdata_q <= byte_put(rdata_q, byte_q, sh_q);
                      if (last_byte)
                        fsm_q <= SM_ISTOP;
                      else
                        byte_q <= byte_q + 2'b01;
                    end
                  endcase
                end
              end
            end
          end
        end
        SM_ISTOP: begin
          if (tick) begin
            if (qtr_q == 2'd0) begin
              sda_oe <= 1'b1;
              qtr_q  <= 2'd1;
            end else if (qtr_q == 2'd1) begin
              scl_oe <= 1'b0;
              qtr_q  <= 2'd2;
            end else if (qtr_q == 2'd2) begin
              if (scl_s)
                qtr_q <= 2'd3;
            end else begin
              sda_oe <= 1'b0;
              fsm_q  <= SM_DONE;
            end
          end
        end
        SM_SBIT: begin
          if (tick) begin
            if (qtr_q == 2'd0) begin
              scl_o <= 1'b0;
              sda_o <= sh_q[7];
              if (tw_q && rd_q && sb_q >= 6'd8)
                sda_oe <= 1'b0;
              qtr_q <= 2'd1;
            end else if (qtr_q == 2'd1) begin
              qtr_q <= 2'd2;
            end else if (qtr_q == 2'd2) begin
              scl_o <= 1'b1;
              sh_q  <= {sh_q[6:0], spi_miso};
              qtr_q <= 2'd3;
            end else begin
              qtr_q <= 2'd0;
              if (sb_q[2:0] == 3'b111) begin
                if (sb_q != 6'd7)
                  rdata_q <= byte_put(rdata_q, blk - 2'b01, sh_q);
                sh_q <= byte_sel(wdata_q, blk);
              end
              if (sb_q == sb_last)
                fsm_q <= SM_SEND;
              else
                sb_q <= sb_q + 6'h01;
            end
          end
        end
        SM_SEND: begin
          if (tick) begin
            cs_o <= 1'b1;
            fsm_q <= SM_DONE;
          end
        end
        SM_DONE: begin
          busy_q <= 1'b0;
          fsm_q  <= SM_IDLE;
        end
        default: begin
          fsm_q <= SM_IDLE;
        end
      endcase
    end
  end

endmodule // srp_host

// ===== verification/srp_host_monitor.sv
// checker for the serial port host: apb timing and pin shapes
// assumes bind to srp_host; pins are seen as the host drives them
`timescale 1ns/1ns
module srp_host_monitor (
  // clock and reset
  input wire mclk,
  input wire rst,
  // apb
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  // pins
  input wire cs_o,
  input wire scl_i,
  input wire scl_o,
  input wire scl_oe,
  input wire sda_o,
  input wire sda_oe
);
  reg [7:0] gap_q;
  reg [5:0] rise_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // cycles since scl was last let go
  always @(posedge mclk) begin
    if (rst) gap_q <= 8'hff;
    else if ($fell(scl_oe)) gap_q <= 8'h00;
    else if (gap_q != 8'hff) gap_q <= gap_q + 8'h01;
  end

  // rising clock edges within one spi frame
  always @(posedge mclk) begin
    if (rst || cs_o) rise_q <= 6'h00;
    else if ($rose(scl_o) && $past(scl_oe)) rise_q <= rise_q + 6'h01;
  end

  AST_APB_ZERO_WAIT: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not one cycle after setup");
  AST_APB_ERR_TIMING: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_SPI_OWNS_CLOCK: assert property (!cs_o |-> scl_oe)
    else $error("clock not driven in spi frame");
  AST_CS_CLOCK_PARKED: assert property ($changed(cs_o) |-> scl_o && scl_oe)
    else $error("chip select moved with clock low");
  AST_SPI_DATA_ON_FALL: assert property (!cs_o && $past(!cs_o) && sda_oe
    && $past(sda_oe) && $changed(sda_o) |-> $fell(scl_o))
    else $error("spi data changed off the falling edge");
  AST_SPI_HALF_BIT: assert property (!cs_o && $fell(scl_o)
    |-> ##[20:30] $rose(scl_o))
    else $error("spi clock low phase out of range");
  AST_SPI_CLOCK_COUNT: assert property ($rose(cs_o)
    |-> rise_q inside {6'h10, 6'h18, 6'h20, 6'h28})
    else $error("spi frame clock count wrong");
  AST_I2C_BIT_RATE: assert property (cs_o && $fell(scl_oe)
    |-> gap_q >= 8'h31)
    else $error("i2c clock faster than fast mode");
  AST_I2C_STRETCH: assert property (cs_o && $rose(scl_oe) |-> $past(scl_i))
    else $error("scl pulled low while held by device");
endmodule // srp_host_monitor

bind srp_host srp_host_monitor srp_host_monitor_inst (.mclk(mclk), .rst(rst),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .cs_o(cs_o), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe),
  .sda_o(sda_o), .sda_oe(sda_oe));

// ===== verification/srp_dev.sv
// behavioural sensor port: i2c and 3/4-wire spi slave with a byte file
// assumes the bench resolves the wires, pulled up when released
`timescale 1ns/1ns
module srp_dev #(
  parameter TW_BIT   = 0,
  parameter AINC_BIT = 4
) (
  // strap, pacing, clock for idle noise
  input  wire strap,
  input  wire slow,
  input  wire mclk,
  // resolved pins
  input  wire cs,
  input  wire scl,
  input  wire sda,
  // drivers
  output reg  sda_oe,
  output reg  sda_o,
  output reg  scl_dn,
  output reg  spi_data_out
);
  reg  [7:0] mem [0:127];
  reg  [7:0] b;
  reg  [7:0] sb;
  reg  [6:0] ptr;
  reg  [6:0] sa;
  reg        rd;
  integer    i, k, n, cond;
  wire       ainc = mem[7'h11][AINC_BIT];
  wire       w3   = mem[7'h10][TW_BIT];

  initial begin
    for (k = 0; k < 128; k = k + 1) mem[k] = 8'h00;
    mem[7'h11] = 8'h10;
    sda_oe = 0; sda_o = 0; scl_dn = 0; spi_data_out = 0; rd = 0; n = 0;
  end

  // cond: 0 byte, 1 start, 2 stop or gone
  task rx_byte;
    begin
      cond = 0;
      for (i = 0; i < 8 && cond == 0; i = i + 1) begin
        @(posedge scl or negedge cs);
        if (!cs) cond = 2;
        else begin
          b = {b[6:0], sda};
          @(negedge scl or sda);
          if (scl) cond = sda ? 2 : 1;
        end
      end
    end
  endtask

  task ack;
    begin
      sda_oe = 1; sda_o = 0;
      @(negedge scl);
      sda_oe = 0;
      if (slow) begin
        scl_dn = 1; #3000 scl_dn = 0;
      end
    end
  endtask

  task tx_bytes;
    begin
      k = 0;
      while (k == 0) begin
        b = mem[ptr]; ptr = ptr + {6'h00, ainc};
        for (i = 0; i < 8; i = i + 1) begin
          sda_oe = ~b[7]; sda_o = 0; b = b << 1;
          @(negedge scl);
        end
        sda_oe = 0;
        @(posedge scl) k = sda;
        @(negedge scl);
      end
    end
  endtask

  always @(negedge sda) if (scl && cs) begin
    cond = 1;
    while (cond == 1) begin
      rx_byte;
      if (cond == 0 && b[7:1] == {6'h2e, strap}) begin
        ack;
        if (b[0]) tx_bytes;
        else begin
          rx_byte;
          if (cond == 0) begin
            ptr = b[6:0]; ack;
          end
          while (cond == 0) begin
            rx_byte;
            if (cond == 0) begin
              mem[ptr] = b; ptr = ptr + {6'h00, ainc}; ack;
            end
          end
        end
      end else if (cond == 0) cond = 2;
    end
  end

  always @(negedge cs) begin
    n = 0; rd = 0;
    while (!cs) begin
      @(posedge scl or posedge cs);
      if (!cs) begin
        sb = {sb[6:0], sda}; n = n + 1;
        if (n == 8) begin
          rd = sb[7]; sa = sb[6:0];
        end else if (n % 8 == 0) begin
          if (!rd) mem[sa] = sb;
          sa = sa + {6'h00, ainc};
        end
      end
    end
    sda_oe = 0;
  end

  always @(negedge scl) if (!cs && rd && n >= 8) begin
    if (w3) sda_oe = 1;
    sda_o = mem[sa][7 - n % 8];
    spi_data_out = mem[sa][7 - n % 8];
  end

  // an undriven output toggles instead of holding its last bit
  always @(posedge mclk) if (cs || !rd || n < 8 || w3) spi_data_out <= ~spi_data_out;
endmodule // srp_dev

// ===== verification/srp_host_tb_top.sv
// self-checking bench: apb stimulus into srp_host, srp_dev on the pins
// assumes srp_map.vh offsets and pulled-up open-drain wires
`timescale 1ns/1ns
`include "srp_map.vh"
module srp_host_tb_top;
  reg         mclk, rst, psel, penable, pwrite, strap, slow, rerr;
  reg  [7:0]  paddr;
  reg  [6:0]  ad;
  reg  [31:0] pwdata, rdat, wd;
  wire [31:0] prdata;
  wire        pready, pslverr, cs_o, scl_o, scl_oe, sda_o, sda_oe;
  wire        d_oe, d_o, d_dn, sdo_w, scl_w, sda_w;
  integer     fails, samples_checked, seed, m, it, cnt, k;

  assign scl_w = (scl_oe ? scl_o : 1'b1) & ~d_dn;
  assign sda_w = (sda_oe ? sda_o : 1'b1) & (d_oe ? d_o : 1'b1);

  srp_host srp_host_inst (.mclk(mclk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cs_o(cs_o),
    .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe(sda_oe), .sdo_i(sdo_w));
  srp_dev srp_dev_inst (.strap(strap), .slow(slow), .mclk(mclk),
    .cs(cs_o), .scl(scl_w), .sda(sda_w), .sda_oe(d_oe), .sda_o(d_o),
    .scl_dn(d_dn), .spi_data_out(sdo_w));

  initial begin
    mclk = 0;
    forever #25 mclk = ~mclk;
  end

  function [31:0] msk(input integer n);
    msk = (n == 4) ? 32'hffff_ffff : (32'h0000_0001 << (8 * n)) - 1;
  endfunction

  task summarize;
    begin
      if (fails == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask

  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      samples_checked = samples_checked + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
    end
  endtask

  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge mclk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge mclk);
      penable <= 1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      rdat = prdata; rerr = pslverr;
      psel <= 0; penable <= 0;
    end
  endtask

  // one transfer; nk expects a refused address and sends the wrong address lsb
  task xfer(input s, input r, input t, input [1:0] c, input [6:0] a,
            input [31:0] d, input nk);
    begin
      apb(1, `SRP_OFF_ADDR, {25'h0, a});
      apb(1, `SRP_OFF_WDATA, d);
      apb(1, `SRP_OFF_CTRL, {25'h0, c, ~nk, t, r, s, 1'b1});
      rdat = 0;
      while (rdat[`SRP_STAT_DONE] !== 1'b1) apb(0, `SRP_OFF_STATUS, 0);
      chk("status", {29'h0, nk, 2'b10}, rdat);
      apb(1, `SRP_OFF_STATUS, 32'h0000_0006);
    end
  endtask

  initial begin
    #4_000_000;
    fails = fails + 1;
    summarize;
  end

  initial begin
    seed = 32'h9345; fails = 0; samples_checked = 0; rst = 1; strap = 1;
    psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; slow = 0;
    repeat (4) @(posedge mclk);
    rst <= 0;
    for (k = 0; k < 6; k = k + 1) begin
      apb(0, 8'(4 * k), 0);
      if (k < 5) chk("reset word", 0, rdat);
      chk("slverr", {31'h0, k == 5}, {31'h0, rerr});
    end
    xfer(0, 0, 0, 2'h0, 7'h20, 32'h0000_00a5, 1);
    chk("nack no write", 0, srp_dev_inst.mem[7'h20]);
    apb(0, `SRP_OFF_STATUS, 0);
    chk("status clear", 0, rdat);
    for (m = 0; m < 3; m = m + 1) begin
      if (m == 2) xfer(1, 0, 0, 2'h0, 7'h10, 32'h0000_0001, 0);
      for (it = 0; it < 2; it = it + 1) begin
        slow <= (m == 0 && it == 1);
        cnt = 1 + ($random(seed) & 3);
        ad = 7'(8'h20 + ($random(seed) & 8'h3f));
        wd = $random(seed);
        xfer(m > 0, 0, m == 2, 2'(cnt - 1), ad, wd, 0);
        for (k = 0; k < cnt; k = k + 1)
          chk("device byte", wd[8*k +: 8], srp_dev_inst.mem[ad + k]);
        xfer(m > 0, 1, m == 2, 2'(cnt - 1), ad, 0, 0);
        apb(0, `SRP_OFF_RDATA, 0);
        chk("read data", wd & msk(cnt), rdat & msk(cnt));
      end
      if (m == 1) begin
        xfer(1, 0, 0, 2'h0, 7'h11, 32'h0000_0000, 0);
        xfer(1, 0, 0, 2'h1, 7'h30, 32'h0000_5a3c, 0);
        chk("fixed addr", 32'h5a, srp_dev_inst.mem[7'h30]);
        xfer(1, 1, 0, 2'h1, 7'h30, 0, 0);
        apb(0, `SRP_OFF_RDATA, 0);
        chk("same byte", 32'h5a5a, {16'h0, rdat[15:0]});
        xfer(1, 0, 0, 2'h0, 7'h11, 32'h0000_0010, 0);
      end
    end
    summarize;
  end
endmodule // srp_host_tb_top
